// ---- disk_serdes_and_bus_latches.sv ----
// Purpose: data/clock serial chains and bus latches of a disk channel
// Assumes: strobes and serial lines arrive unsynchronised from the
//          interface board; microprogram pulses are on clk_i
// Notes: all state sits in one struct registered by one process
// Functional notes
// - shift read data into chained nibble registers
// - full data chain drives array input bus
// - first two data stages go out
// - load only when empty and write gate
// - load array bits 0-7 ascending into chain
// - write data is inverted last stage
// - shift read clock bits into chained registers
// - full clock chain offered on alternate inputs
// - clock load puts zeros in fixed stages
// - two stages load AND of mark controls
// - second register stage 0 loads mark b
// - opcode pulse latches bits 0-5 inverted
// - opcode bits select instruction and drive unit
// - address pulse latches address, driven when master
// - low strobe latches low data byte
// - high strobe latches high data byte
// - high byte driven: master, memwrite, 16-bit
// - low byte driven on memwrite or result
// - input strobe captures both system bytes
// - memory strobe captures both system bytes
// - byte select gates one input latch
// - mastership level only while holding bus
// - status flag shows chain full or empty
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module disk_serdes_and_bus_latches #(
    parameter int unsigned ADR_W = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // serial link from the interface board
    input wire logic serial_rd_data_n_i,
    input wire logic rd_data_strobe_i,
    input wire logic serial_rd_clkbit_n_i,
    input wire logic rd_clkbit_strobe_i,
    input wire logic mem_data_strobe_i,
    input wire logic byte_select_level_i,
    input wire logic bus_selected_i,
    output logic serial_wr_data_o,
    output logic in_bit0_n_o,
    output logic in_bit1_n_o,
    output logic par_load_n_o,
    output logic sr_flag_o,
    output logic unit_sel_a_o,
    output logic unit_sel_b_o,
    // processing array side
    input wire logic [7:0] array_out_i,
    input wire logic opcode_load_pulse_i,
    input wire logic addr_load_pulse_i,
    input wire logic low_byte_strobe_i,
    input wire logic high_byte_strobe_i,
    input wire logic input_latch_strobe_i,
    output serdes_pkg::array_in_t array_in_o,
    output logic mode16_o,
    // system bus pins
    input wire logic [15:0] sys_data_i,
    output serdes_pkg::sysbus_out_t sysbus_o
);

    serdes_pkg::state_t q;
    serdes_pkg::state_t d;
    serdes_pkg::pins_t pins;

    // strobe edges, chain state and bus decode
    logic d_edge;
    logic c_edge;
    logic m_edge;
    logic d_done;
    logic c_done;
    logic d_load;
    logic c_load;
    logic mark_and;
    logic wb_req;
    logic [3:0] ofs;

    // advance a chain counter: 1..8, wrapping after a full byte
    function automatic logic [3:0] count_up(input logic [3:0] c);
        count_up = (c == serdes_pkg::CHAIN_LEN) ? 4'h1 : c + 4'h1;
    endfunction

    // clock byte for a load: only three stages follow the mark levels,
    // the rest are tied low, so address marks differ only there
    function automatic logic [7:0] clk_pattern(input logic a,
                                               input logic b);
        logic both;
        both = a & b;
        // stages 7..0: 0, 0, a&b, b, a&b, 0, 0, 0
        clk_pattern = {2'b00, both, b, both, 3'b000};
    endfunction

    // every pin from the interface board and the system bus is gathered
    // here so that the sampling stages treat them alike; the cost is
    // that sys_data_i and the levels also wait two clocks

    assign pins = '{sys_data: sys_data_i,
                    selected: bus_selected_i,
                    byte_sel: byte_select_level_i,
                    mem_stb: mem_data_strobe_i,
                    clk_stb: rd_clkbit_strobe_i,
                    clk_n: serial_rd_clkbit_n_i,
                    data_stb: rd_data_strobe_i,
                    data_n: serial_rd_data_n_i};

    // edges are found on the second stage so the first stays clean
    assign d_edge = q.s2.data_stb & ~q.s3.data_stb;
    assign c_edge = q.s2.clk_stb & ~q.s3.clk_stb;
    assign m_edge = q.s2.mem_stb & ~q.s3.mem_stb;
    assign d_done = (q.dcnt == serdes_pkg::CHAIN_LEN);
    assign c_done = (q.ccnt == serdes_pkg::CHAIN_LEN);
    // the clock chain judges emptiness on its own count, since its
    // strobe may lag the data strobe that already reloaded the data
    assign d_load = d_done & q.ctrl[serdes_pkg::CTL_WGATE];
    assign c_load = c_done & q.ctrl[serdes_pkg::CTL_WGATE];
    assign mark_and = q.ctrl[serdes_pkg::CTL_MARK_A]
                    & q.ctrl[serdes_pkg::CTL_MARK_B];
    assign wb_req = cyc_i & stb_i;
    assign ofs = {adr_i[3:2], 2'b00};

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.ctrl[serdes_pkg::CTL_CLEAR] = 1'b0;


        // a load replaces the shift on the strobe that finds the chain
        // empty, so no bit time is lost between bytes
        if (d_edge) begin
            if (d_load) begin
                d.dsr = array_out_i;
                d.dcnt = 4'h0;
            end else begin
                d.dsr = {q.dsr[6:0], q.s2.data_n};
                d.dcnt = count_up(q.dcnt);
            end
        end


        // the clock chain keeps its own count and may lag the data chain
        if (c_edge) begin
            if (c_load) begin
                d.csr = clk_pattern(q.ctrl[serdes_pkg::CTL_MARK_A],
                                    q.ctrl[serdes_pkg::CTL_MARK_B]);
                d.ccnt = 4'h0;
            end else begin
                d.csr = {q.csr[6:0], q.s2.clk_n};
                d.ccnt = count_up(q.ccnt);
            end
        end


        // a software clear beats a strobe in the same clock: the count
        // restarts and a bit shifted then simply goes uncounted
        if (q.ctrl[serdes_pkg::CTL_CLEAR]) begin
            d.dcnt = 4'h0;
            d.ccnt = 4'h0;
        end


        // array-side latches act on every clock the pulse is high, so a
        // pulse held two clocks simply loads the same byte twice
        if (opcode_load_pulse_i) begin
            d.opc = ~array_out_i[5:0];
        end
        if (addr_load_pulse_i) begin
            d.addr = array_out_i;
        end
        if (low_byte_strobe_i) begin
            d.dlo = array_out_i;
        end
        if (high_byte_strobe_i) begin
            d.dhi = array_out_i;
        end
        // a memory strobe and an input strobe mean the same capture
        if (input_latch_strobe_i || m_edge) begin
            d.din = q.s2.sys_data;
        end


        // ack one cycle after the request, dropped the cycle after;
        // a write lands at the edge that samples ack high, while the
        // master still holds its request
        d.ack = wb_req & ~q.ack;
        if (wb_req && !q.ack) begin
            unique case (ofs)
                serdes_pkg::CTRL_OFS: d.rdat = {26'h0, q.ctrl};
                // status: bit 25 mastership, bit 24 flag, then counts
                // and both chains, so software sees a frame in one read
                serdes_pkg::STAT_OFS: d.rdat = {6'h0, q.s2.selected,
                    d_done, q.ccnt, q.dcnt, q.csr, q.dsr};
                serdes_pkg::LATCH_OFS: d.rdat = {2'h0, q.opc, q.addr,
                    q.dhi, q.dlo};
                serdes_pkg::INLAT_OFS: d.rdat = {16'h0, q.din};
                default: d.rdat = 32'h0;
            endcase
        end
        if (wb_req && q.ack && we_i && sel_i[0]
            && ofs == serdes_pkg::CTRL_OFS) begin
            d.ctrl = dat_i[serdes_pkg::CTL_W-1:0];
        end


        // reset comes last so that it overrides every update above
        if (rst_i) begin
            d = '0;
            d.ctrl = serdes_pkg::CTRL_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // data outputs come from registers, the load enable from gates
    assign dat_o = q.rdat;
    assign ack_o = q.ack;
    assign serial_wr_data_o = ~q.dsr[7];
    assign in_bit0_n_o = q.dsr[0];
    assign in_bit1_n_o = q.dsr[1];
    assign par_load_n_o = ~d_load;
    assign sr_flag_o = d_done;
    assign unit_sel_a_o = q.opc[4];
    assign unit_sel_b_o = q.opc[5];
    assign mode16_o = q.opc[3];

    assign array_in_o.data_bits = q.dsr;
    assign array_in_o.clock_bits = q.csr;
    assign array_in_o.prim_sel = q.opc[2:0];
    // only one latch reaches the memory-data inputs at a time
    assign array_in_o.mem_data = q.s2.byte_sel ? q.din[7:0]
                                               : q.din[15:8];

    // bus drivers appear as enables beside the latched values; the pads
    // outside turn them into the three-state lines
    assign sysbus_o.addr = q.addr;
    assign sysbus_o.addr_oe = q.s2.selected;
    assign sysbus_o.data = {q.dhi, q.dlo};
    assign sysbus_o.data_oe_hi = q.s2.selected & mode16_o
                               & q.ctrl[serdes_pkg::CTL_MEM_WR];
    assign sysbus_o.data_oe_lo = q.ctrl[serdes_pkg::CTL_MEM_WR]
                               | q.ctrl[serdes_pkg::CTL_RD_RES];

    // all checks run on the system clock and sleep during reset; the
    // link strobes are seen only through their sampling stages
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    shift_in_a: assert property (d_edge && !d_load |=>
        q.dsr == {$past(q.dsr[6:0]), $past(q.s2.data_n)})
        else $error("data chain did not shift");
    load_data_a: assert property (d_edge && d_load |=>
        q.dsr == $past(array_out_i) && !sr_flag_o)
        else $error("data chain load wrong");
    load_gate_a: assert property (!par_load_n_o |->
        sr_flag_o && q.ctrl[serdes_pkg::CTL_WGATE])
        else $error("load enabled while not empty");
    ser_out_a: assert property (d_edge && d_load |=>
        serial_wr_data_o == !$past(array_out_i[7]))
        else $error("write data not inverted msb");
    clk_load_a: assert property (c_edge && c_load |=>
        q.csr == {2'b00, $past(mark_and),
        $past(q.ctrl[serdes_pkg::CTL_MARK_B]), $past(mark_and), 3'b000})
        else $error("clock pattern wrong");
    opcode_lat_a: assert property (opcode_load_pulse_i |=>
        unit_sel_a_o == !$past(array_out_i[4]) &&
        array_in_o.prim_sel == ~$past(array_out_i[2:0]))
        else $error("opcode latch wrong");
    hi_enable_a: assert property (sysbus_o.data_oe_hi |->
        sysbus_o.addr_oe && mode16_o && q.ctrl[serdes_pkg::CTL_MEM_WR])
        else $error("high byte driven wrongly");
    in_latch_a: assert property (input_latch_strobe_i |=>
        q.din == $past(q.s2.sys_data))
        else $error("input latch missed");
    full_flag_a: assert property (d_edge && !d_load &&
        q.dcnt == 4'h7 && !q.ctrl[serdes_pkg::CTL_CLEAR] |=> sr_flag_o)
        else $error("chain not full after eight");
    addr_lat_a: assert property (addr_load_pulse_i ##1
        !addr_load_pulse_i |-> sysbus_o.addr == $past(array_out_i))
        else $error("address latch wrong");

    load_seen_c: cover property (d_edge && d_load);
    full_seen_c: cover property (sr_flag_o && !q.ctrl[0]);
    mark_seen_c: cover property (c_edge && c_load && mark_and);
    mem_stb_c: cover property (m_edge);
    clear_seen_c: cover property (q.ctrl[serdes_pkg::CTL_CLEAR]);

    // serial clock chain
    clk_shift_a: assert property (c_edge && !c_load |=>
        q.csr == {$past(q.csr[6:0]), $past(q.s2.clk_n)})
        else $error("clock chain did not shift");
    clk_out_a: assert property (c_edge && !c_load |=>
        array_in_o.clock_bits[0] == $past(q.s2.clk_n))
        else $error("clock bit not offered to array");
    clk_full_a: assert property (c_edge && !c_load &&
        q.ccnt == 4'h7 && !q.ctrl[serdes_pkg::CTL_CLEAR] |=>
        q.ccnt == serdes_pkg::CHAIN_LEN)
        else $error("clock chain not full after eight");

    // data chain taps and count clear
    in_bits_a: assert property (d_edge && !d_load |=>
        in_bit0_n_o == $past(q.s2.data_n)
        && in_bit1_n_o == $past(q.dsr[0]))
        else $error("input data bits wrong");
    data_out_a: assert property (d_edge && !d_load |=>
        array_in_o.data_bits[7:1] == $past(q.dsr[6:0]))
        else $error("data byte not offered to array");
    clear_cnt_a: assert property (q.ctrl[serdes_pkg::CTL_CLEAR] |=>
        q.dcnt == 4'h0 && q.ccnt == 4'h0 && !sr_flag_o)
        else $error("clear left a count");

    // data-flow latches
    low_lat_a: assert property (low_byte_strobe_i |=>
        sysbus_o.data[7:0] == $past(array_out_i))
        else $error("low data latch wrong");
    high_lat_a: assert property (high_byte_strobe_i |=>
        sysbus_o.data[15:8] == $past(array_out_i))
        else $error("high data latch wrong");
    mode_lat_a: assert property (opcode_load_pulse_i |=>
        mode16_o == !$past(array_out_i[3])
        && unit_sel_b_o == !$past(array_out_i[5]))
        else $error("mode or unit select wrong");
    mem_lat_a: assert property (m_edge |=>
        q.din == $past(q.s2.sys_data))
        else $error("memory data not captured");
    lo_gate_a: assert property (q.s2.byte_sel |->
        array_in_o.mem_data == q.din[7:0])
        else $error("low input latch not gated");
    hi_gate_a: assert property (!q.s2.byte_sel |->
        array_in_o.mem_data == q.din[15:8])
        else $error("high input latch not gated");
    lo_enable_a: assert property (q.ctrl[serdes_pkg::CTL_RD_RES] |->
        sysbus_o.data_oe_lo)
        else $error("low byte not driven for result");

    // register bus handshake
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than a cycle");
    ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    ctrl_wr_a: assert property (cyc_i && stb_i && ack_o && we_i
        && sel_i[0] && ofs == serdes_pkg::CTRL_OFS |=>
        q.ctrl == $past(dat_i[serdes_pkg::CTL_W-1:0]))
        else $error("control write lost");

endmodule

// ---- serdes_pkg.sv ----
// Purpose: shared constants and carriers for the disk serdes and latches
// Assumes: one 50 MHz clock; wishbone registers on 32-bit words
// Notes: offsets are byte addresses of aligned words
package serdes_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam logic [3:0] CHAIN_LEN = 4'h8;
    // register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] LATCH_OFS = 4'h8;
    localparam logic [3:0] INLAT_OFS = 4'hc;
    // control field positions
    localparam int unsigned CTL_WGATE = 0;
    localparam int unsigned CTL_MARK_A = 1;
    localparam int unsigned CTL_MARK_B = 2;
    localparam int unsigned CTL_MEM_WR = 3;
    localparam int unsigned CTL_RD_RES = 4;
    localparam int unsigned CTL_CLEAR = 5;
    localparam int unsigned CTL_W = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // pins from the interface board and system bus, all asynchronous
    typedef struct packed {
        logic [15:0] sys_data;
        logic selected;
        logic byte_sel;
        logic mem_stb;
        logic clk_stb;
        logic clk_n;
        logic data_stb;
        logic data_n;
    } pins_t;
    // what the processing array sees
    typedef struct packed {
        logic [7:0] data_bits;
        logic [7:0] clock_bits;
        logic [7:0] mem_data;
        logic [2:0] prim_sel;
    } array_in_t;
    // system bus drive, latched values with their output enables
    typedef struct packed {
        logic [7:0] addr;
        logic addr_oe;
        logic [15:0] data;
        logic data_oe_lo;
        logic data_oe_hi;
    } sysbus_out_t;
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        pins_t s3;
        logic [7:0] dsr;
        logic [7:0] csr;
        logic [3:0] dcnt;
        logic [3:0] ccnt;
        logic [5:0] opc;
        logic [7:0] addr;
        logic [7:0] dlo;
        logic [7:0] dhi;
        logic [15:0] din;
        logic [5:0] ctrl;
        logic ack;
        logic [31:0] rdat;
    } state_t;
endpackage

// ---- link_model.sv ----
// Purpose: interface board model for the serial read link and memory strobe
// Assumes: strobe period 160 ns, unrelated to the system clock
// Notes: strobes rest low between frames
`timescale 1ns/1ns
module link_model (
    // serial link to the channel
    output logic data_n_o,
    output logic data_stb_o,
    output logic clk_n_o,
    output logic clk_stb_o,
    output logic mem_stb_o
);
    initial begin
        data_n_o = 1'h0;
        data_stb_o = 1'h0;
        clk_n_o = 1'h0;
        clk_stb_o = 1'h0;
        mem_stb_o = 1'h0;
    end
    // msb first, so the first bit ends in the top stage
    task automatic frame(input logic [7:0] d, c, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            data_n_o = d[i];
            clk_n_o = c[i];
            #40;
            data_stb_o = 1'h1;
            clk_stb_o = 1'h1;
            #80;
            data_stb_o = 1'h0;
            clk_stb_o = 1'h0;
            #40;
        end
        // released lines must not keep showing the last bit
        data_n_o = ~data_n_o;
        clk_n_o = ~clk_n_o;
    endtask
    task automatic mem_pulse();
        mem_stb_o = 1'h1;
        #80;
        mem_stb_o = 1'h0;
        #40;
    endtask
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the serdes chains and bus latches
// Assumes: wishbone answers in one cycle
// Notes: link model makes the strobes
`timescale 1ns/1ns
module testbench;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic dn, ds, cn, cs, ms, bsel, bus_sel;
    logic wr_o, id0, id1, pl_n, flag, unit_sel_a, usb, m16;
    logic [7:0] aout;
    logic [4:0] pls;
    logic [15:0] sys_d;
    serdes_pkg::array_in_t ain;
    serdes_pkg::sysbus_out_t sb;
    int n_fail = 0;
    int comparisons = 0;
    link_model link_u (.data_n_o(dn), .data_stb_o(ds), .clk_n_o(cn),
        .clk_stb_o(cs), .mem_stb_o(ms));
    disk_serdes_and_bus_latches dut_u (.clk_i, .rst_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .serial_rd_data_n_i(dn), .rd_data_strobe_i(ds),
        .serial_rd_clkbit_n_i(cn), .rd_clkbit_strobe_i(cs),
        .mem_data_strobe_i(ms), .byte_select_level_i(bsel),
        .bus_selected_i(bus_sel), .serial_wr_data_o(wr_o),
        .in_bit0_n_o(id0), .in_bit1_n_o(id1), .par_load_n_o(pl_n),
        .sr_flag_o(flag), .unit_sel_a_o(unit_sel_a), .unit_sel_b_o(usb),
        .array_out_i(aout), .opcode_load_pulse_i(pls[0]),
        .addr_load_pulse_i(pls[1]), .low_byte_strobe_i(pls[2]),
        .high_byte_strobe_i(pls[3]), .input_latch_strobe_i(pls[4]),
        .array_in_o(ain), .mode16_o(m16), .sys_data_i(sys_d),
        .sysbus_o(sb));
    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'h1 && k < 20);
        rd = dat_o;
        if (k >= 20) begin
            n_fail++;
            $display("BAD ack expected 1 seen none");
            end_of_test();
        end
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    // one-cycle array pulse with its data byte
    task automatic pulse(input int i, input logic [7:0] v);
        @(posedge clk_i);
        aout <= v;
        pls[i] <= 1'h1;
        @(posedge clk_i);
        pls[i] <= 1'h0;
        tick(3);
    endtask
    task automatic t_read();
        chk("load_n", pl_n, 16'h1);
        link_u.frame(8'ha5, 8'h3c, 8);
        tick(2);
        chk("data", ain.data_bits, 16'ha5);
        chk("clkbits", ain.clock_bits, 16'h3c);
        chk("id0", id0, 16'h1);
        chk("id1", id1, 16'h0);
        chk("flag", flag, 16'h1);
        $display("read test done");
    endtask
    task automatic t_write();
        for (int k = 0; k < 2; k++) begin
            wb(1'h1, serdes_pkg::CTRL_OFS, k ? 32'h7 : 32'h5);
            @(posedge clk_i);
            aout <= k ? 8'h96 : 8'h69;
            tick(3);
            chk("load_n", pl_n, 16'h0);
            link_u.frame(8'h00, 8'h00, 1);
            tick(2);
            chk("dload", ain.data_bits, k ? 16'h96 : 16'h69);
            chk("wr_data", wr_o, k ? 16'h0 : 16'h1);
            chk("cload", ain.clock_bits, k ? 16'h38 : 16'h10);
            chk("load_n", pl_n, 16'h1);
            link_u.frame(8'hff, 8'hff, 8);
        end
        $display("write test done");
    endtask
    task automatic t_latch();
        bus_sel <= 1'h1;
        pulse(0, 8'h2d);
        chk("prim", ain.prim_sel, 16'h2);
        chk("usa", unit_sel_a, 16'h1);
        chk("usb", usb, 16'h0);
        chk("m16", m16, 16'h0);
        pulse(1, 8'h5a);
        chk("addr", sb.addr, 16'h5a);
        chk("addr_oe", sb.addr_oe, 16'h1);
        pulse(2, 8'hc3);
        pulse(3, 8'h7e);
        chk("sdata", sb.data, 16'h7ec3);
        wb(1'h1, serdes_pkg::CTRL_OFS, 32'h8);
        tick(2);
        chk("oe_lo", sb.data_oe_lo, 16'h1);
        chk("oe_hi", sb.data_oe_hi, 16'h0);
        pulse(0, 8'h25);
        chk("oe_hi", sb.data_oe_hi, 16'h1);
        chk("m16", m16, 16'h1);
        wb(1'h1, serdes_pkg::CTRL_OFS, 32'h10);
        bus_sel <= 1'h0;
        tick(4);
        chk("oe_lo", sb.data_oe_lo, 16'h1);
        chk("oe_hi", sb.data_oe_hi, 16'h0);
        chk("addr_oe", sb.addr_oe, 16'h0);
        $display("latch test done");
    endtask
    task automatic t_input();
        sys_d <= 16'hbeef;
        bsel <= 1'h1;
        tick(3);
        pulse(4, 8'h00);
        chk("mem_lo", ain.mem_data, 16'hef);
        bsel <= 1'h0;
        tick(4);
        chk("mem_hi", ain.mem_data, 16'hbe);
        sys_d <= 16'h1234;
        tick(3);
        link_u.mem_pulse();
        tick(4);
        chk("mem_strobe", ain.mem_data, 16'h12);
        wb(1'h0, serdes_pkg::INLAT_OFS, 32'h0);
        chk("inlat", rd[15:0], 16'h1234);
        $display("input test done");
    endtask
    task automatic t_regs();
        wb(1'h0, serdes_pkg::STAT_OFS, 32'h0);
        chk("stat_lo", rd[15:0], 16'hffff);
        chk("stat_hi", rd[31:16], 16'h0188);
        wb(1'h0, serdes_pkg::LATCH_OFS, 32'h0);
        chk("lat_lo", rd[15:0], 16'h7ec3);
        chk("lat_hi", rd[31:16], 16'h1a5a);
        wb(1'h1, serdes_pkg::CTRL_OFS, 32'h30);
        tick(2);
        chk("cleared", flag, 16'h0);
        wb(1'h0, serdes_pkg::STAT_OFS, 32'h0);
        chk("stat_clr", rd[31:16], 16'h0000);
        sel_i <= 4'he;
        wb(1'h1, serdes_pkg::CTRL_OFS, 32'h1);
        sel_i <= 4'hf;
        wb(1'h0, serdes_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", rd[15:0], 16'h0010);
        rst_i <= 1'h1;
        tick(2);
        rst_i <= 1'h0;
        chk("rst_flag", flag, 16'h0);
        chk("rst_wr", wr_o, 16'h1);
        chk("rst_usa", unit_sel_a, 16'h0);
        chk("rst_m16", m16, 16'h0);
        chk("rst_oe_lo", sb.data_oe_lo, 16'h0);
        chk("rst_load_n", pl_n, 16'h1);
        tick(2);
        $display("register test done");
    endtask
    initial begin
        rst_i = 1'h1;
        cyc_i = 1'h0;
        stb_i = 1'h0;
        we_i = 1'h0;
        adr_i = 4'h0;
        sel_i = 4'hf;
        dat_i = 32'h0;
        aout = 8'h00;
        pls = 5'h00;
        sys_d = 16'h0000;
        bsel = 1'h0;
        bus_sel = 1'h0;
        tick(5);
        rst_i <= 1'h0;
        t_read();
        t_write();
        t_latch();
        t_input();
        t_regs();
        end_of_test();
    end
endmodule
